// *** rtl/ewps_pkg.sv ***
package ewps_pkg;
  localparam logic [7:0] EWPS_CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] EWPS_CMD_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] EWPS_CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] EWPS_CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] EWPS_CMD_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] EWPS_CMD_ARRAY_READ = 8'h03;
  localparam int EWPS_BIT_PIN_GUARD_EN = 7;
  localparam int EWPS_BIT_GUARD_HI = 3;
  localparam int EWPS_BIT_GUARD_LO = 2;
  localparam int EWPS_BIT_LATCH = 1;
  localparam int EWPS_BIT_BUSY = 0;
  localparam logic [9:0] EWPS_QUARTER_BASE = 10'h300;
  localparam logic [9:0] EWPS_HALF_BASE = 10'h200;
  localparam logic [2:0] EWPS_NV_RESET = 3'h0;
  localparam int EWPS_CLK_HZ = 20000000;
  localparam int EWPS_WRITE_TIME_US = 5000;
  localparam int EWPS_WRITE_CYCLES = EWPS_CLK_HZ / 1000000 * EWPS_WRITE_TIME_US;
  typedef struct packed {
    logic pin_guard_enable;
    logic block_guard_hi;
    logic block_guard_lo;
  } ewps_nv_t;
  typedef enum logic [1:0] {
    EWPS_IDLE = 2'b00,
    EWPS_CMD = 2'b01,
    EWPS_DATA = 2'b10,
    EWPS_SKIP = 2'b11
  } ewps_state_t;
endpackage : ewps_pkg

// *** rtl/ewps_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ewps_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_rst_val,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_prev
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] level_reg;
  // a change counts once the second and third stage agree
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_reg <= i_rst_val;
      s2_reg <= i_rst_val;
      s3_reg <= i_rst_val;
      level_reg <= i_rst_val;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int k = 0; k < WIDTH; k++) begin
        if (s2_reg[k] == s3_reg[k]) begin
          level_reg[k] <= s3_reg[k];
        end
      end
    end
  end
  assign o_level = level_reg;
  assign o_prev = s3_reg;
endmodule : ewps_sync
`default_nettype wire

// *** rtl/ewps_core.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RQ1] no internal write without latch set
// [RQ2] latch set command sets, clear clears
// [RQ3] latch clears at reset and after writes
// [RQ4] status readable anytime, even while busy
// [RQ5] status byte layout guard en..busy
// [RQ6] busy flag high during internal write
// [RQ7] latch flag shows latch state
// [RQ8] latch commands ignore hardware protection
// [RQ9] block guard bits change only by status write
// [RQ10] block guard ranges gate array writes
// [RQ11] guard enable bit enables protect pin
// [RQ12] protect active when pin low, enable high
// [RQ13] hardware protect blocks only status writes
// [RQ14] host ends frame after exact clock count
// [RQ15] array commands ignored while busy
// [RQ16] standby, output off until select falls
// [RQ17] opcodes 06, 04, 05, 01
// [RQ18] latch set takes effect at frame end
// [RQ19] all bits most significant first
// [RQ20] started write completes despite pin change
// [RQ21] status write updates only three bits
module ewps_core
  import ewps_pkg::*;
#(
  parameter int WRITE_CYCLES = EWPS_WRITE_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe,
  output logic o_busy,
  output logic o_array_write
);
  // the write counter is 24 bits wide, so longer write times cannot be served
  if (WRITE_CYCLES < 1 || WRITE_CYCLES > 2 ** 24 - 1) begin : g_bad_write_cycles
    $error("WRITE_CYCLES out of range");
  end
  logic [3:0] pins_lvl;
  ewps_sync #(.WIDTH(4)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_sck, i_si, i_wp_n}),
    // serial clock idles low in mode 0, so reset must not fake an edge
    .i_rst_val(4'h9),
    .o_level(pins_lvl),
    .o_prev()
  );
  logic cs_reg;
  logic sck_reg;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cs_reg <= 1'b1;
      sck_reg <= 1'b0;
    end else begin
      cs_reg <= pins_lvl[3];
      sck_reg <= pins_lvl[2];
    end
  end
  wire cs_fall = cs_reg & ~pins_lvl[3];
  wire cs_rise = ~cs_reg & pins_lvl[3];
  wire selected = ~pins_lvl[3];
  wire sck_rise = selected & ~sck_reg & pins_lvl[2];
  wire sck_fall = selected & sck_reg & ~pins_lvl[2];
  wire si_bit = pins_lvl[1];
  wire wp_n = pins_lvl[0];
  ewps_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] cmd_reg;
  logic [4:0] bit_cnt_reg;
  logic [5:0] byte_cnt_reg;
  logic [9:0] addr_reg;
  logic latch_reg;
  ewps_nv_t nv_reg;
  ewps_nv_t nv_pend_reg;
  logic wp_frame_reg;
  logic [23:0] busy_cnt_reg;
  logic busy_reg;
  logic [7:0] so_shift_reg;
  logic so_reg;
  logic so_oe_reg;
  logic array_write_reg;
  wire busy = busy_reg;
  wire [7:0] shift_next = {shift_reg[6:0], si_bit}; // RQ19
  wire [7:0] status_byte = {nv_reg.pin_guard_enable, 3'h0, nv_reg.block_guard_hi,
                            nv_reg.block_guard_lo, latch_reg, busy}; // RQ5 RQ6 RQ7
  wire hw_protect = ~wp_n & nv_reg.pin_guard_enable; // RQ11 RQ12
  function automatic logic guarded(input ewps_nv_t nv, input logic [9:0] addr);
    case ({nv.block_guard_hi, nv.block_guard_lo})
      2'b01: guarded = addr >= EWPS_QUARTER_BASE;
      2'b10: guarded = addr >= EWPS_HALF_BASE;
      2'b11: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded
  // frame ends exactly on a byte boundary: all other ends abort the write
  wire on_byte = bit_cnt_reg[2:0] == 3'h0;
  wire end_latch_set = cmd_reg == EWPS_CMD_LATCH_SET && bit_cnt_reg == 5'd8;
  wire end_latch_clr = cmd_reg == EWPS_CMD_LATCH_CLEAR && bit_cnt_reg == 5'd8;
  wire end_status_wr = cmd_reg == EWPS_CMD_STATUS_WRITE && bit_cnt_reg == 5'd16
                       && byte_cnt_reg == 6'd0;
  wire end_array_wr = cmd_reg == EWPS_CMD_ARRAY_WRITE && byte_cnt_reg != 6'd0 && on_byte;
  // pin protection latched whenever seen while selected in the frame; once busy, pin changes are ignored
  wire status_go = end_status_wr & latch_reg & ~wp_frame_reg & ~busy; // RQ1 RQ13
  wire array_go = end_array_wr & latch_reg & ~busy & ~guarded(nv_reg, addr_reg); // RQ1 RQ10
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= EWPS_IDLE;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      bit_cnt_reg <= 5'h00;
      byte_cnt_reg <= 6'h00;
      addr_reg <= 10'h000;
      latch_reg <= 1'b0; // RQ3
      nv_reg <= EWPS_NV_RESET;
      nv_pend_reg <= EWPS_NV_RESET;
      wp_frame_reg <= 1'b0;
      busy_cnt_reg <= 24'h000000;
      busy_reg <= 1'b0;
      so_shift_reg <= 8'h00;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0; // RQ16
      array_write_reg <= 1'b0;
    end else begin
      array_write_reg <= 1'b0;
      if (busy) begin
        busy_cnt_reg <= busy_cnt_reg - 24'h000001; // RQ20
      end
      busy_reg <= busy_cnt_reg > 24'h000001; // RQ6
      if (cs_fall) begin // RQ16
        state_reg <= EWPS_CMD;
        bit_cnt_reg <= 5'h00;
        byte_cnt_reg <= 6'h00;
        wp_frame_reg <= 1'b0;
      end else if (cs_rise) begin // RQ14 RQ18
        state_reg <= EWPS_IDLE;
        so_oe_reg <= 1'b0;
        if (end_latch_set) begin
          latch_reg <= 1'b1; // RQ2 RQ8
        end else if (end_latch_clr) begin
          latch_reg <= 1'b0; // RQ2 RQ3 RQ8
        end else if (status_go) begin
          nv_reg <= nv_pend_reg; // RQ9 RQ21
          latch_reg <= 1'b0; // RQ3
          busy_cnt_reg <= 24'(WRITE_CYCLES);
          busy_reg <= 1'b1; // RQ6
        end else if (array_go) begin
          latch_reg <= 1'b0; // RQ3
          busy_cnt_reg <= 24'(WRITE_CYCLES);
          busy_reg <= 1'b1; // RQ6
          array_write_reg <= 1'b1;
        end
      end else if (selected) begin
        if (hw_protect) begin
          wp_frame_reg <= 1'b1; // RQ13
        end
        if (sck_rise && state_reg != EWPS_IDLE && state_reg != EWPS_SKIP) begin
          shift_reg <= shift_next;
          // past the address, every further data byte counts over 24..31 again
          bit_cnt_reg <= (bit_cnt_reg == 5'd31) ? 5'd24 : bit_cnt_reg + 5'd1;
          if (state_reg == EWPS_CMD && bit_cnt_reg == 5'd7) begin
            cmd_reg <= shift_next; // RQ17
            state_reg <= EWPS_DATA;
            if (busy && (shift_next == EWPS_CMD_ARRAY_WRITE ||
                         shift_next == EWPS_CMD_ARRAY_READ)) begin
              state_reg <= EWPS_SKIP; // RQ15
            end
            if (shift_next == EWPS_CMD_STATUS_READ) begin
              so_shift_reg <= status_byte; // RQ4
            end
          end else if (state_reg == EWPS_DATA && bit_cnt_reg[2:0] == 3'h7) begin
            if (cmd_reg == EWPS_CMD_STATUS_WRITE && bit_cnt_reg == 5'd15) begin
              nv_pend_reg <= {shift_next[EWPS_BIT_PIN_GUARD_EN],
                              shift_next[EWPS_BIT_GUARD_HI],
                              shift_next[EWPS_BIT_GUARD_LO]}; // RQ21
            end
            if (cmd_reg == EWPS_CMD_ARRAY_WRITE) begin
              if (bit_cnt_reg == 5'd15) begin
                addr_reg[9:8] <= shift_next[1:0];
              end else if (bit_cnt_reg == 5'd23) begin
                addr_reg[7:0] <= shift_next;
              end else if (bit_cnt_reg == 5'd31 && byte_cnt_reg != 6'h3F) begin
                byte_cnt_reg <= byte_cnt_reg + 6'd1;
              end
            end
            if (cmd_reg == EWPS_CMD_STATUS_WRITE && bit_cnt_reg == 5'd23) begin
              byte_cnt_reg <= 6'd1;
            end
          end
        end
        if (sck_fall && state_reg == EWPS_DATA && cmd_reg == EWPS_CMD_STATUS_READ) begin
          so_oe_reg <= 1'b1;
          so_reg <= so_shift_reg[7]; // RQ19
          so_shift_reg <= {so_shift_reg[6:0], so_shift_reg[7]};
          if (bit_cnt_reg[2:0] == 3'h0 && bit_cnt_reg != 5'd8) begin
            so_reg <= status_byte[7]; // RQ4
            so_shift_reg <= {status_byte[6:0], status_byte[7]};
          end
        end
      end
    end
  end
  assign o_so = so_reg;
  assign o_so_oe = so_oe_reg;
  assign o_busy = busy_reg;
  assign o_array_write = array_write_reg;

  latch_needed_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ1
    $rose(o_busy) |-> $past(latch_reg))
    else $error("write started without latch");
  latch_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ2
    (cs_rise && end_latch_set) |=> latch_reg)
    else $error("latch not set");
  latch_cleared_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ3
    $rose(o_busy) |-> !latch_reg)
    else $error("latch not cleared after write");
  busy_flag_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ6
    status_byte[0] == (busy_cnt_reg != 24'h000000))
    else $error("busy flag mismatch");
  status_lock_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ9
    (nv_reg != $past(nv_reg)) |-> $past(cs_rise && status_go))
    else $error("guard bits changed without status write");
  guard_block_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ10
    o_array_write |-> !guarded(nv_reg, addr_reg))
    else $error("write into guarded block");
  hw_protect_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ13
    (cs_rise && end_status_wr && wp_frame_reg) |=> !o_busy || $past(o_busy))
    else $error("status write under hardware protect");
  busy_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ20
    (busy_cnt_reg > 24'h000001) |=> o_busy)
    else $error("internal write cut short");
  idle_quiet_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ16
    !selected |=> !o_so_oe)
    else $error("output driven while deselected");
  busy_start_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ6
    (cs_rise && (status_go || array_go)) |=> o_busy)
    else $error("accepted write did not raise busy");
  busy_skip_a: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ15
    (cs_rise && busy) |=> !o_array_write)
    else $error("array write accepted while busy");
endmodule : ewps_core
`default_nettype wire

// *** tb/ewps_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ewps_host #(
  parameter int HALF = 4
) (
  input wire logic i_mclk,
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_rd_valid,
  output logic [7:0] o_rd_byte
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_byte = 8'h00;
  end
  // idle data line toggles so a stale bit never passes for a real one
  always @(posedge i_mclk) if (o_cs_n) o_si <= ~o_si;
  // mode 0, msb first, select released after the whole count
  task automatic frame(input logic [31:0] dout, input int nbits, input bit rd);
    logic [7:0] sh;
    sh = 8'h00;
    @(posedge i_mclk) o_cs_n <= 1'b0;
    repeat (HALF) @(posedge i_mclk);
    for (int i = nbits - 1; i >= 0; i--) begin
      o_si <= dout[i];
      repeat (HALF) @(posedge i_mclk);
      o_sck <= 1'b1;
      repeat (HALF) @(posedge i_mclk);
      // taken at the end of the high phase: the block answers some clocks after the fall
      sh = {sh[6:0], i_so};
      o_sck <= 1'b0;
    end
    repeat (HALF) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_rd_byte <= sh;
    o_rd_valid <= rd;
    @(posedge i_mclk) o_rd_valid <= 1'b0;
    repeat (2 * HALF) @(posedge i_mclk);
  endtask : frame
endmodule : ewps_host
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ewps_pkg::*;
  // short write time keeps the run small but outlasts one status read
  localparam int WCYC = 600;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wp_n = 1'b1;
  logic cs_n, sck, si, so, so_oe, busy, awr, rd_v;
  logic [7:0] rd_b;
  // a released output shows the inverse of its last bit, so a late enable is caught
  wire so_pin = so_oe ? so : ~so;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'h6DAC8980;
  logic en = 1'b0, bh = 1'b0, bl = 1'b0, lat = 1'b0;
  logic [9:0] addr_tab [6] = '{10'h000, 10'h1FF, 10'h200, 10'h2FF, 10'h300, 10'h3FF};
  int err_count = 0;
  int n_checks = 0;
  always #25 i_mclk = ~i_mclk;
  ewps_core #(.WRITE_CYCLES(WCYC)) u_ewps_core (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .o_so(so),
    .o_so_oe(so_oe), .o_busy(busy), .o_array_write(awr));
  ewps_host u_ewps_host (.i_mclk(i_mclk), .i_so(so_pin), .o_cs_n(cs_n), .o_sck(sck),
    .o_si(si), .o_rd_valid(rd_v), .o_rd_byte(rd_b));
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : rnd
  function automatic logic [8:0] st(input logic b);
    return {1'b0, en, 3'b000, bh, bl, lat, b};
  endfunction : st
  task automatic end_sim();
    if (exp_q.size() != 0) err_count++;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : check
  // each pulse or status byte takes the oldest note; a missing one shows up as a shift
  always @(posedge i_mclk) begin
    if (awr === 1'b1 || rd_v === 1'b1)
      check("result", exp_q.size() != 0 ? exp_q.pop_front() : 9'h1FF,
        awr === 1'b1 ? 9'h100 : {1'b0, rd_b});
  end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2 * WCYC) begin
      @(posedge i_mclk);
      n++;
    end
    if (busy !== 1'b0) begin
      err_count++;
      end_sim();
    end
  endtask : wait_idle
  task automatic cmd(input logic [7:0] op);
    u_ewps_host.frame({24'h0, op}, 8, 1'b0);
  endtask : cmd
  task automatic rd_status(input logic b);
    exp_q.push_back(st(b));
    u_ewps_host.frame({16'h0, EWPS_CMD_STATUS_READ, 8'h00}, 16, 1'b1);
  endtask : rd_status
  task automatic wr_status(input logic [7:0] d, input logic wp_after);
    logic ok;
    cmd(EWPS_CMD_LATCH_SET);
    ok = !(en && !i_wp_n);
    u_ewps_host.frame({16'h0, EWPS_CMD_STATUS_WRITE, d}, 16, 1'b0);
    i_wp_n <= wp_after;
    if (ok) begin
      {en, bh, bl, lat} = {d[7], d[3], d[2], 1'b0};
    end else begin
      lat = 1'b1;
    end
    rd_status(ok);
    wait_idle();
    rd_status(1'b0);
  endtask : wr_status
  task automatic wr_array(input logic [9:0] a);
    logic prot;
    prot = (bh && bl) || (bh && a >= EWPS_HALF_BASE) || (bl && a >= EWPS_QUARTER_BASE);
    cmd(EWPS_CMD_LATCH_SET);
    seed = rnd(seed);
    if (!prot) exp_q.push_back(9'h100);
    u_ewps_host.frame({EWPS_CMD_ARRAY_WRITE, 6'h0, a, seed[7:0]}, 32, 1'b0);
    lat = prot;
    wait_idle();
    rd_status(1'b0);
  endtask : wr_array
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    check("idle", 9'h0, {7'h0, so_oe, busy});
    rd_status(1'b0);
    u_ewps_host.frame({EWPS_CMD_ARRAY_WRITE, 16'h0, 8'hA5}, 32, 1'b0);
    u_ewps_host.frame({23'h0, EWPS_CMD_LATCH_SET, 1'b0}, 9, 1'b0);
    rd_status(1'b0);
    cmd(EWPS_CMD_LATCH_SET);
    lat = 1'b1;
    rd_status(1'b0);
    cmd(EWPS_CMD_LATCH_CLEAR);
    lat = 1'b0;
    rd_status(1'b0);
    for (int g = 0; g < 4; g++) begin
      seed = rnd(seed);
      wr_status({1'b0, seed[6:4], g[1:0], seed[1:0]}, 1'b1);
      for (int k = 0; k < 6; k++) begin
        wr_array(addr_tab[k]);
      end
    end
    wr_status(8'h80, 1'b1);
    i_wp_n <= 1'b0;
    wr_status(8'h0C, 1'b0);
    cmd(EWPS_CMD_LATCH_CLEAR);
    lat = 1'b0;
    rd_status(1'b0);
    wr_array(10'h3FF);
    cmd(EWPS_CMD_LATCH_SET);
    exp_q.push_back(9'h100);
    u_ewps_host.frame({EWPS_CMD_ARRAY_WRITE, 16'h0100, 8'h3C}, 32, 1'b0);
    cmd(EWPS_CMD_LATCH_SET);
    u_ewps_host.frame({EWPS_CMD_ARRAY_WRITE, 16'h0101, 8'hC3}, 32, 1'b0);
    lat = 1'b1;
    rd_status(1'b1);
    wait_idle();
    i_wp_n <= 1'b1;
    wr_status(8'h88, 1'b0);
    i_wp_n <= 1'b1;
    wr_status(8'h00, 1'b1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
